/* File: rtl/bldc_map.vh */
/*
  constants for the sensorless three-phase commutation and pwm block.
  assumes a single 125 mhz clock and inputs already turned into logic levels or codes.
*/
`ifndef BLDC_MAP_VH
`define BLDC_MAP_VH

`define CLK_HZ            125000000
`define RETRY_TIME_MS     1000
`define PWM_BITS          8
`define PWM_LAST          8'hFF
`define DUTY_BITS         6
`define DUTY_ZERO         6'h00
`define FORCED_BASE       65536
`define MAX_COMM_CYCLES   2048
`define RATE_MID          2'h1
`define RATE_LOW          2'h0
`define STEP_FIRST        3'h0
`define STEP_LAST         3'h5
`define ST_IDLE           3'h0
`define ST_ALIGN          3'h1
`define ST_FORCED         3'h2
`define ST_SENSORLESS     3'h3
`define ST_FAULT          3'h4
`define PH_U              3'h1
`define PH_V              3'h2
`define PH_W              3'h4
`define PH_NONE           3'h0

`endif

/* File: rtl/level_sync.v */
/*
  two flip-flop synchroniser, one bit per lane.
  assumes each lane is a slow level from outside the clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

module level_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage    <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage    <= async_in;
      sync_out <= stage;
    end
  end

endmodule // level_sync

`default_nettype wire

/* File: rtl/bldc_commutation.v */
/*
  sensorless three-phase brushless commutation and pwm controller.
  assumes outside comparators and a 6-bit converter deliver asynchronous levels, synchronised here.
*/
// Contract
// - align, then forced, then back-emf commutation
// - alignment ends when timing node drops
// - startup duty from startup duty node
// - faster than forced rate enters sensorless
// - forced step 2^16, 2^17, 2^18 clocks
// - pwm period is 256 clocks
// - 6-bit speed code sets duty
// - duty zero, n/64, saturating at 63/64
// - fault disables gate drives (duty monitor keeps running), retries after one second
// - too fast or too slow is fault
// - position sampled on falling pwm edge
// - zero lead forced, selected lead sensorless
// - overlap select high gives plain 120 degree
// - overlap length follows lead setting
// - low side active high, high side selectable
// - overcurrent stops all gate drives and the duty monitor
// - monitor shows speed duty and overcurrent
`timescale 1ns/1ns
`default_nettype none
`include "bldc_map.vh"

module bldc_commutation #(
  parameter RETRY_CYCLES    = (`CLK_HZ / 1000) * `RETRY_TIME_MS,
  parameter FORCED_BASE     = `FORCED_BASE,
  parameter MAX_COMM_CYCLES = `MAX_COMM_CYCLES
) (
  input  wire       clk,
  input  wire       reset_n,
  input  wire [5:0] speed_command_input,
  input  wire [5:0] startup_duty_node,
  input  wire       excitation_timing_node,
  input  wire [1:0] startup_rate_select,
  input  wire [2:0] position_sense,
  input  wire       advance_angle_select,
  input  wire       overlap_select,
  input  wire       highside_polarity_select,
  input  wire       rotation_direction,
  input  wire       overcurrent_sense,
  output reg        u_high_drive,
  output reg        u_low_drive,
  output reg        v_high_drive,
  output reg        v_low_drive,
  output reg        w_high_drive,
  output reg        w_low_drive,
  output reg        duty_monitor,
  output reg        fault_active,
  output reg  [2:0] motor_state
);

  wire [22:0] pin_sync;
  wire [5:0]  speed_sync   = pin_sync[5:0];
  wire [5:0]  startup_sync = pin_sync[11:6];
  wire [2:0]  pos_sync     = pin_sync[14:12];
  wire [1:0]  rate_sync    = pin_sync[16:15];
  wire        excite_sync  = pin_sync[17];
  wire        lead_sync    = pin_sync[18];
  wire        overlap_sync = pin_sync[19];
  wire        pol_sync     = pin_sync[20];
  wire        dir_sync     = pin_sync[21];
  wire        oc_sync      = pin_sync[22];
  level_sync #(.WIDTH(23)) sync_pins (.clk(clk), .reset_n(reset_n), .sync_out(pin_sync),
    .async_in({overcurrent_sense, rotation_direction, highside_polarity_select, overlap_select,
               advance_angle_select, excitation_timing_node, startup_rate_select, position_sense,
               startup_duty_node, speed_command_input}));

  reg [7:0]  pwm_cnt;
  reg [5:0]  duty_now;
  reg [5:0]  speed_duty;
  reg        pwm_on_q;
  reg [2:0]  state;
  reg [2:0]  step;
  reg [2:0]  prev_step;
  reg [31:0] timer;
  reg [19:0] interval;
  reg [19:0] comm_delay;
  reg        comm_pending;
  reg [19:0] overlap_cnt;
  reg [2:0]  pos_sampled;
  reg        edge_seen;
  reg [19:0] period;
  // a duty code is only taken at the period boundary, so a mid-period change cannot split a pulse
  wire       period_end = (pwm_cnt == `PWM_LAST);
  wire       pwm_on     = (pwm_cnt[7:2] < duty_now);
  wire       mon_on     = (pwm_cnt[7:2] < speed_duty);
  wire       pwm_fall   = pwm_on_q & ~pwm_on;
  wire       pos_edge   = pwm_fall & (pos_sync != pos_sampled);
  wire       running    = (speed_sync != `DUTY_ZERO);
  wire [31:0] forced_full = (rate_sync == `RATE_LOW) ? FORCED_BASE * 4 :
                            (rate_sync == `RATE_MID) ? FORCED_BASE * 2 : FORCED_BASE;
  wire [19:0] forced_len  = forced_full[19:0];
  // natural zero crossing sits 30 degrees ahead of the ideal commutation point
  wire [19:0] lead_delay = lead_sync ? (interval >> 2) : ((interval >> 2) + (interval >> 3));
  // overlap is a share of the last edge spacing, not of the time since the edge
  wire [19:0] overlap_len = lead_sync ? (period >> 2) : (period >> 3);

  function [2:0] next_step;
    input [2:0] s;
    input       fwd;
    begin
      if (fwd)
        next_step = (s == `STEP_LAST) ? `STEP_FIRST : s + 3'h1;
      else
        next_step = (s == `STEP_FIRST) ? `STEP_LAST : s - 3'h1;
    end
  endfunction
  function [2:0] high_of;
    input [2:0] s;
    begin
      case (s)
        3'h0, 3'h1: high_of = `PH_U;
        3'h2, 3'h3: high_of = `PH_V;
        3'h4, 3'h5: high_of = `PH_W;
        default:    high_of = `PH_NONE;
      endcase
    end
  endfunction
  function [2:0] low_of;
    input [2:0] s;
    begin
      case (s)
        3'h0, 3'h5: low_of = `PH_V;
        3'h1, 3'h2: low_of = `PH_W;
        3'h3, 3'h4: low_of = `PH_U;
        default:    low_of = `PH_NONE;
      endcase
    end
  endfunction

  // pwm carrier and duty selection
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwm_cnt    <= 8'h00;
      duty_now   <= `DUTY_ZERO;
      speed_duty <= `DUTY_ZERO;
      pwm_on_q   <= 1'b0;
    end else begin
      pwm_cnt  <= pwm_cnt + 8'h01;
      pwm_on_q <= pwm_on;
      if (period_end) begin
        speed_duty <= speed_sync;
        duty_now <= (state == `ST_SENSORLESS) ? speed_sync : startup_sync;
      end
    end
  end

  // start-up sequence, commutation and fault retry
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state        <= `ST_IDLE;
      step         <= `STEP_FIRST;
      prev_step    <= `STEP_FIRST;
      timer        <= 32'h0000_0000;
      interval     <= 20'h00000;
      comm_delay   <= 20'h00000;
      comm_pending <= 1'b0;
      overlap_cnt  <= 20'h00000;
      pos_sampled  <= 3'h0;
      edge_seen    <= 1'b0;
      period       <= 20'h00000;
    end else begin
      if (pwm_fall)
        pos_sampled <= pos_sync;
      if (pos_edge)
        period <= interval;
      if (overlap_cnt != 20'h00000)
        overlap_cnt <= overlap_cnt - 20'h00001;
      if (interval != 20'hFFFFF)
        interval <= interval + 20'h00001;
      case (state)
        `ST_IDLE: begin
          step      <= `STEP_FIRST;
          prev_step <= `STEP_FIRST;
          edge_seen <= 1'b0;
          if (running)
            state <= `ST_ALIGN;
        end
        `ST_ALIGN: begin
          timer    <= 32'h0000_0000;
          interval <= 20'h00000;
          if (!running)
            state <= `ST_IDLE;
          else if (!excite_sync)
            state <= `ST_FORCED;
        end
        `ST_FORCED: begin
          if (!running) begin
            state <= `ST_IDLE;
          end else if (pos_edge && edge_seen && interval < forced_len) begin
            state        <= `ST_SENSORLESS;
            interval     <= 20'h00000;
            comm_delay   <= lead_delay;
            comm_pending <= 1'b1;
          end else begin
            if (pos_edge) begin
              edge_seen <= 1'b1;
              interval  <= 20'h00000;
            end
            if (timer >= {12'h000, forced_len} - 32'h1) begin
              timer     <= 32'h0000_0000;
              prev_step <= step;
              step      <= next_step(step, dir_sync);
            end else begin
              timer <= timer + 32'h1;
            end
          end
        end
        `ST_SENSORLESS: begin
          if (!running) begin
            state <= `ST_IDLE;
          end else if ((pos_edge && interval < MAX_COMM_CYCLES) || interval >= forced_len) begin
            state <= `ST_FAULT;
            timer <= 32'h0000_0000;
          end else begin
            if (pos_edge) begin
              interval     <= 20'h00000;
              comm_delay   <= lead_delay;
              comm_pending <= 1'b1;
            end else if (comm_pending) begin
              if (comm_delay == 20'h00000) begin
                comm_pending <= 1'b0;
                prev_step    <= step;
                step         <= next_step(step, dir_sync);
                if (!overlap_sync)
                  overlap_cnt <= overlap_len;
              end else begin
                comm_delay <= comm_delay - 20'h00001;
              end
            end
          end
        end
        `ST_FAULT: begin
          comm_pending <= 1'b0;
          overlap_cnt  <= 20'h00000;
          // retry goes through alignment again, so a persistent fault loops here every second
          if (timer >= RETRY_CYCLES - 1)
            state <= `ST_IDLE;
          else
            timer <= timer + 32'h1;
        end
        default: state <= `ST_IDLE;
      endcase
    end
  end

  // gate drive: the high side carries the chopping, the low side stays on for the whole step
  reg [2:0] hi_act;
  reg [2:0] lo_act;
  reg       drive_ok;
  always @* begin
    drive_ok = (state == `ST_ALIGN || state == `ST_FORCED || state == `ST_SENSORLESS) && !oc_sync;
    hi_act   = high_of(step);
    lo_act   = low_of(step);
    if (overlap_cnt != 20'h00000) begin
      hi_act = hi_act | high_of(prev_step);
      lo_act = lo_act | low_of(prev_step);
    end
    if (!drive_ok || !pwm_on)
      hi_act = `PH_NONE;
    if (!drive_ok)
      lo_act = `PH_NONE;
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      u_high_drive <= 1'b0;
      v_high_drive <= 1'b0;
      w_high_drive <= 1'b0;
      u_low_drive  <= 1'b0;
      v_low_drive  <= 1'b0;
      w_low_drive  <= 1'b0;
      duty_monitor <= 1'b0;
      fault_active <= 1'b0;
      motor_state  <= `ST_IDLE;
    end else begin
      u_high_drive <= hi_act[0] ^ pol_sync;
      v_high_drive <= hi_act[1] ^ pol_sync;
      w_high_drive <= hi_act[2] ^ pol_sync;
      u_low_drive  <= lo_act[0];
      v_low_drive  <= lo_act[1];
      w_low_drive  <= lo_act[2];
      duty_monitor <= mon_on & ~oc_sync;
      fault_active <= (state == `ST_FAULT);
      motor_state  <= state;
    end
  end

endmodule // bldc_commutation

`default_nettype wire

/* File: dv/bldc_commutation_properties.sv */
/* port assertions for the commutation block.
   assumes one clock and an async active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module bldc_commutation_checker #(
  parameter RETRY_CYCLES = 1000
) (
  input wire       clk,
  input wire       reset_n,
  input wire       overlap_select,
  input wire       highside_polarity_select,
  input wire       overcurrent_sense,
  input wire       u_high_drive,
  input wire       u_low_drive,
  input wire       v_high_drive,
  input wire       v_low_drive,
  input wire       w_high_drive,
  input wire       w_low_drive,
  input wire       duty_monitor,
  input wire       fault_active,
  input wire [2:0] motor_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire [2:0]  lows = {u_low_drive, v_low_drive, w_low_drive};
  reg  [31:0] fault_len;
  // a repetition cannot hold a count this long, so count it here
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      fault_len <= 32'h0;
    else
      fault_len <= fault_active ? fault_len + 32'h1 : 32'h0;
  end
  oc_blank_a: assert property (overcurrent_sense[*5] |-> lows == 3'h0 && !duty_monitor)
    else $error("drives live in overcurrent");
  oc_high_a: assert property ((overcurrent_sense && $stable(highside_polarity_select))[*5]
    |-> {u_high_drive, v_high_drive, w_high_drive} == {3{highside_polarity_select}})
    else $error("high side not idle");
  plain_onehot_a: assert property (overlap_select[*5] |-> $onehot0(lows))
    else $error("low sides overlap");
  fault_off_a: assert property (fault_active[*2] |-> lows == 3'h0)
    else $error("drive during fault");
  retry_len_a: assert property ($fell(fault_active)
    |-> fault_len >= RETRY_CYCLES - 2 && fault_len <= RETRY_CYCLES + 2)
    else $error("retry wait length");
  state_order_a: assert property ($changed(motor_state) |-> motor_state == 3'h0
    || motor_state == 3'h4 || motor_state == $past(motor_state) + 3'h1)
    else $error("bad state order");
  align_step_a: assert property ((motor_state == 3'h1 && !overcurrent_sense)[*6] |-> lows == 3'h2)
    else $error("align not on step 0");
  idle_off_a: assert property ((motor_state == 3'h0)[*2] |-> lows == 3'h0)
    else $error("drive while idle");
endmodule // bldc_commutation_checker
bind bldc_commutation bldc_commutation_checker #(.RETRY_CYCLES(RETRY_CYCLES)) i_chk (
  .clk(clk), .reset_n(reset_n), .overlap_select(overlap_select),
  .highside_polarity_select(highside_polarity_select), .overcurrent_sense(overcurrent_sense),
  .u_high_drive(u_high_drive), .u_low_drive(u_low_drive), .v_high_drive(v_high_drive),
  .v_low_drive(v_low_drive), .w_high_drive(w_high_drive), .w_low_drive(w_low_drive),
  .duty_monitor(duty_monitor), .fault_active(fault_active), .motor_state(motor_state));
`default_nettype wire

/* File: dv/phase_model.sv */
/* back-emf polarity comparators of a turning motor.
   assumes gap in clocks per 60 degrees; run low means a stalled rotor. */
`timescale 1ns/1ns
`default_nettype none
module phase_model (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        run,
  input  wire [15:0] gap,
  output wire [2:0]  position_sense
);
  reg [17:0] pattern;
  reg [15:0] count;
  // six patterns, one bit flips per step; a short gap is the too-fast fault
  assign position_sense = pattern[17:15];
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pattern <= 18'h2CC99;
      count   <= 16'h0;
    end else if (run) begin
      count <= (count >= gap - 16'h1) ? 16'h0 : count + 16'h1;
      if (count >= gap - 16'h1)
        pattern <= {pattern[14:0], pattern[17:15]};
    end
  end
endmodule // phase_model
`default_nettype wire

/* File: dv/test_sensorless_bldc_commutation_pwm.sv */
/* self-checking bench for the commutation block.
   assumes shortened retry and forced counts set at the instance. */
`timescale 1ns/1ns
`default_nettype none
module test_sensorless_bldc_commutation_pwm;
  reg        clk, reset_n, timing, adv, ovl, pol, dir, oc, run;
  reg  [5:0] speed, sd;
  reg  [1:0] rate;
  reg [15:0] gap;
  wire       uh, ul, vh, vl, wh, wl, dm, fa;
  wire [2:0] pos, state;
  wire [2:0] lows = {ul, vl, wl};
  integer    fails = 0, cmp_count = 0, seed = 52612, i, t, ov0, ov1, run_len;
  reg  [2:0] last = 0, lw;
  reg  [8:0] dcnt, hcnt;
  reg [31:0] want;
  logic [2:0] exp_q[$];
  always #4 clk = ~clk;
  bldc_commutation #(.RETRY_CYCLES(1000), .FORCED_BASE(256), .MAX_COMM_CYCLES(300)) i_dut (
    .clk(clk), .reset_n(reset_n), .speed_command_input(speed), .startup_duty_node(sd),
    .excitation_timing_node(timing), .startup_rate_select(rate), .position_sense(pos),
    .advance_angle_select(adv), .overlap_select(ovl), .highside_polarity_select(pol),
    .rotation_direction(dir), .overcurrent_sense(oc), .u_high_drive(uh), .u_low_drive(ul),
    .v_high_drive(vh), .v_low_drive(vl), .w_high_drive(wh), .w_low_drive(wl),
    .duty_monitor(dm), .fault_active(fa), .motor_state(state));
  phase_model i_phase (.clk(clk), .reset_n(reset_n), .run(run), .gap(gap), .position_sense(pos));
  task check(input logic [31:0] seen, input logic [31:0] wanted);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== wanted) begin
        fails = fails + 1;
        $display("ERROR %0t: seen %0h wanted %0h", $time, seen, wanted);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task wait_state(input logic [2:0] s);
    begin
      t = 0;
      while (state !== s && t < 6000) begin
        @(negedge clk);
        t = t + 1;
      end
      check(state, s);
    end
  endtask
  task count_on;
    begin
      dcnt = 0;
      hcnt = 0;
      repeat (256) begin
        @(negedge clk);
        dcnt = dcnt + dm;
        hcnt = hcnt + (({uh, vh, wh} ^ {3{pol}}) != 3'h0);
      end
    end
  endtask
  // each state change is matched against the oldest expected one
  always @(negedge clk) begin
    if (reset_n && state !== last) begin
      last = state;
      check(state, exp_q.size() ? exp_q.pop_front() : 3'h7);
    end
  end
  initial begin
    // about twice the roughly 25000 cycles the scenarios need
    #400000;
    fails = fails + 1;
    give_verdict;
  end
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    timing = 1'b1;
    adv = 1'b0;
    ovl = 1'b1;
    pol = 1'b0;
    dir = 1'b1;
    oc = 1'b0;
    run = 1'b0;
    speed = 6'h00;
    sd = 6'h00;
    rate = 2'h3;
    gap = 16'd600;
    repeat (12) @(negedge clk);
    reset_n = 1;
    repeat (4) @(negedge clk);
    check({uh, vh, wh, lows}, 6'h00);
    for (i = 0; i < 4; i = i + 1) begin
      speed = (i == 0) ? 6'h01 : (i == 1) ? 6'h3F : 6'h01 + $unsigned($random(seed)) % 63;
      sd = 6'h01 + $unsigned($random(seed)) % 63;
      rate = 2'h3 - i[1:0];
      dir = (i != 3);
      pol = (i == 1);
      exp_q.push_back(3'h1);
      repeat (600) @(negedge clk);
      count_on;
      check(dcnt, speed * 4);
      check(hcnt, sd * 4);
      timing = 0;
      exp_q.push_back(3'h2);
      wait_state(3'h2);
      want = (32'd256 << (rate[1] ? 0 : rate[0] ? 1 : 2)) * (dir ? 1 : 2);
      lw = lows;
      t = 0;
      while (lows === lw && t < 3000) begin
        @(negedge clk);
        t = t + 1;
      end
      check(t + 4 >= want && t <= want + 4, 1);
      check(lows, dir ? 3'h1 : 3'h4);
      speed = 0;
      timing = 1;
      exp_q.push_back(3'h0);
      repeat (600) @(negedge clk);
      count_on;
      check(dcnt, 0);
    end
    speed = 6'h28;
    pol = 0;
    dir = 1;
    exp_q.push_back(3'h1);
    repeat (600) @(negedge clk);
    for (i = 0; i < 2; i = i + 1) begin
      timing = 0;
      run = 1;
      exp_q.push_back(3'h2);
      exp_q.push_back(3'h3);
      wait_state(3'h3);
      repeat (600) @(negedge clk);
      count_on;
      check(hcnt, 160);
      if (i == 0) begin
        oc = 1;
        repeat (10) @(negedge clk);
        check({lows, dm}, 4'h0);
        oc = 0;
        run = 0;
        timing = 1;
        exp_q.push_back(3'h4);
        exp_q.push_back(3'h0);
        exp_q.push_back(3'h1);
        wait_state(3'h4);
        repeat (3) @(negedge clk);
        check({fa, lows}, 4'h8);
        wait_state(3'h1);
      end
    end
    ovl = 0;
    ov0 = 0;
    ov1 = 0;
    run_len = 0;
    // longest overlap per lead setting, so the number of steps in each half does not matter
    for (i = 0; i < 6000; i = i + 1) begin
      adv = (i >= 3000);
      @(negedge clk);
      run_len = ((lows & (lows - 3'h1)) != 3'h0) ? run_len + 1 : 0;
      if (adv && run_len > ov1)
        ov1 = run_len;
      if (!adv && run_len > ov0)
        ov0 = run_len;
    end
    check(ov1 > ov0 && ov0 > 0, 1);
    gap = 100;
    exp_q.push_back(3'h4);
    wait_state(3'h4);
    @(negedge clk);
    check(exp_q.size(), 0);
    give_verdict;
  end
endmodule // test_sensorless_bldc_commutation_pwm
`default_nettype wire
